// file: shared/sacc_params.svh
// Constants for the SAR conversion control block
`ifndef SACC_PARAMS_SVH
`define SACC_PARAMS_SVH
// Conversion clock select codes
`define SACC_CS_DIV8 3'h1
`define SACC_CS_DIV16 3'h5
`define SACC_CS_DIV32 3'h2
`define SACC_CS_DIV64 3'h6
// Half periods (system clocks) of each divided bit clock
`define SACC_HALF_DIV8 6'h04
`define SACC_HALF_DIV16 6'h08
`define SACC_HALF_DIV32 6'h10
`define SACC_HALF_DIV64 6'h20
// Bit periods per full conversion, and after an abort
`define SACC_CONV_PERIODS 4'hB
`define SACC_ABORT_PERIODS 4'h2
// Result bits
`define SACC_RES_BITS 10
// Reset values
`define SACC_RESULT_RST 10'h000
`define SACC_CHAN_RST 5'h00
`endif

// file: shared/sacc_pkg.sv
// Types of the SAR conversion control block
package sacc_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        SACC_IDLE,
        SACC_CONVERT,
        SACC_ABORT_WAIT
    } sacc_state_t;
endpackage : sacc_pkg

// file: shared/sacc_tick_if.sv
// Bit clock tick link between the sequencer and its clock generator
interface sacc_tick_if;
    logic [2:0] clock_select; // Conversion clock select code
    logic run; // Divider runs while high
    logic tick; // One-cycle bit period pulse
    // Sequencer side
    modport ctrl (output clock_select, output run, input tick);
    // Clock generator side
    modport gen (input clock_select, input run, output tick);
endinterface : sacc_tick_if

// file: rtl/sacc_tick_gen.sv
// Conversion bit period tick generator
`include "sacc_params.svh"
module sacc_tick_gen (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Internal RC bit clock, asynchronous
    input wire logic rc_clock_in,
    // Tick link
    sacc_tick_if.gen tick_if
);
    // ---------------------------------------------
    // Divider
    // ---------------------------------------------
    logic [6:0] count_reg; // Cycles within bit period
    logic [6:0] count_next;
    logic [2:0] rc_sync_reg; // Two-flop sync plus edge history
    logic [2:0] rc_sync_next;
    logic [6:0] period; // Full bit period in clocks

    // Period decode; any code other than the four dividers (x11 or x00) means RC clock
    always_comb begin
        unique case (tick_if.clock_select)
            `SACC_CS_DIV8: period = {`SACC_HALF_DIV8, 1'b0};
            `SACC_CS_DIV16: period = {`SACC_HALF_DIV16, 1'b0};
            `SACC_CS_DIV32: period = {`SACC_HALF_DIV32, 1'b0};
            `SACC_CS_DIV64: period = {`SACC_HALF_DIV64, 1'b0};
            default: period = 7'h00;
        endcase
    end

    // Next count and RC edge history
    always_comb begin
        rc_sync_next = {rc_sync_reg[1:0], rc_clock_in};
        count_next = 7'h00;
        if (tick_if.run && period != 7'h00 && count_reg != period - 7'h01)
        begin
            count_next = count_reg + 7'h01;
        end
    end

    // [RQ3] Divider or RC select
    assign tick_if.tick = !tick_if.run ? 1'b0 :
        (period == 7'h00) ? (rc_sync_reg[1] && !rc_sync_reg[2]) :
        (count_reg == period - 7'h01);

    // Registers only
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_reg <= 7'h00;
            rc_sync_reg <= 3'h0;
        end else begin
            count_reg <= count_next;
            rc_sync_reg <= rc_sync_next;
        end
    end
endmodule : sacc_tick_gen

// file: rtl/sacc_control.sv
// SAR converter sequencing and result logic
`include "sacc_params.svh"
// Behaviour
// [RQ1] Eleven bit periods per conversion
// [RQ2] Five-bit channel select drives the mux
// [RQ3] Clock select decodes dividers or RC
// [RQ4] Software avoids divide-by-8 at 8 MHz
// [RQ5] Done flag set on every completion
// [RQ6] Done flag cleared by software only
// [RQ7] Interrupt request when flag and enable
// [RQ8] Result right-justified, upper bits zero
// [RQ9] No conversion while enable is clear
// [RQ10] Start write begins a conversion
// [RQ11] Software starts after enabling separately
// [RQ12] Completion clears start, flags, loads result
// [RQ13] Software clear aborts, result kept
// [RQ14] Two periods after abort, then acquire
// [RQ15] Reset disables and ends conversion; reset here ends it, converter_enable_in is an input and is not cleared
// [RQ16] No operation during Sleep
// [RQ17] Software waits acquisition before start
// [RQ18] Software polls or waits for interrupt
// [RQ19] Hold open, MSB first, reconnect on load
// [RQ20] Start ignored while disabled
module sacc_control (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Software control bits
    input wire logic converter_enable_in,
    input wire logic [4:0] input_channel_select_in,
    input wire logic [2:0] conv_clock_select_in,
    input wire logic conversion_irq_enable_in,
    input wire logic start_set_in, // Write of one to start bit
    input wire logic start_clear_in, // Write of zero to start bit
    input wire logic done_flag_clear_in, // Write clearing done flag
    input wire logic sleep_in, // Device in Sleep
    // Analog side
    input wire logic rc_clock_in, // Internal RC bit clock
    input wire logic comparator_in, // SAR comparator, asynchronous
    output logic [4:0] mux_channel_out,
    output logic hold_disconnect_out,
    output logic acquire_out,
    output logic [9:0] dac_code_out,
    // Software status
    output logic start_done_out,
    output logic conversion_done_flag_out,
    output logic conversion_irq_out,
    output logic [7:0] result_high_byte_out,
    output logic [7:0] result_low_byte_out
);
    // ---------------------------------------------
    // Clock generator
    // ---------------------------------------------
    sacc_tick_if tick_if ();
    sacc_tick_gen u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .rc_clock_in(rc_clock_in),
        .tick_if(tick_if)
    );

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    sacc_pkg::sacc_state_t state_reg; // Sequencer state
    sacc_pkg::sacc_state_t state_next;
    logic [3:0] period_reg; // Bit periods elapsed
    logic [3:0] period_next;
    logic [9:0] sar_reg; // Trial code under resolution
    logic [9:0] sar_next;
    logic [9:0] result_reg; // Last completed result
    logic [9:0] result_next;
    logic flag_reg; // Conversion done flag
    logic flag_next;
    logic [1:0] cmp_sync_reg; // Comparator synchroniser
    logic [1:0] cmp_sync_next;
    logic active; // Converter allowed to run
    logic abort_now; // Software abort taken this cycle
    logic done_event; // Conversion completes this cycle

    // [RQ9] Enable gates, [RQ16] Sleep blocks
    assign active = converter_enable_in && !sleep_in;
    // Clock select goes straight to the divider
    assign tick_if.clock_select = conv_clock_select_in;
    // [RQ14] Divider restarts on abort, so the wait is two whole
    // periods; the RC source cannot be restarted, so its first
    // period after an abort may be short
    assign abort_now = active && start_clear_in &&
        state_reg == sacc_pkg::SACC_CONVERT;
    assign tick_if.run = state_reg != sacc_pkg::SACC_IDLE && !abort_now;

    // Trial bit for a period index 1..10
    // Index zero shifts the bit out, giving an empty mask
    function automatic logic [9:0] bit_mask(input logic [3:0] idx);
        bit_mask = 10'h200 >> (idx - 4'h1);
    endfunction : bit_mask

    // ---------------------------------------------
    // Sequencer
    // ---------------------------------------------
    // Sequencer next state; abort outranks a tick in the same cycle
    always_comb begin
        done_event = 1'b0;
        state_next = state_reg;
        period_next = period_reg;
        sar_next = sar_reg;
        result_next = result_reg;
        flag_next = flag_reg;
        unique case (state_reg)
            sacc_pkg::SACC_IDLE: begin
                // [RQ10] Start on selected channel; [RQ20] ignored if off
                if (start_set_in && active) begin
                    state_next = sacc_pkg::SACC_CONVERT;
                    period_next = 4'h0;
                    sar_next = 10'h000;
                end
            end
            sacc_pkg::SACC_CONVERT: begin
                if (!active) begin
                    // Disable or Sleep drops the conversion silently
                    state_next = sacc_pkg::SACC_IDLE;
                end else if (start_clear_in) begin
                    // [RQ13] Abort, keep previous result
                    state_next = sacc_pkg::SACC_ABORT_WAIT;
                    period_next = 4'h0;
                end else if (tick_if.tick) begin
                    // [RQ19] Keep bit if comparator says input above
                    if (period_reg != 4'h0 && cmp_sync_reg[1]) begin
                        sar_next = sar_reg | bit_mask(period_reg);
                    end
                    period_next = period_reg + 4'h1;
                    // [RQ1] Eleventh period ends conversion
                    if (period_reg + 4'h1 == `SACC_CONV_PERIODS) begin
                        state_next = sacc_pkg::SACC_IDLE;
                        // [RQ12] Load result
                        result_next = (cmp_sync_reg[1]) ?
                            (sar_reg | 10'h001) : sar_reg;
                        // [RQ5] Flag set on every completion
                        flag_next = 1'b1;
                        done_event = 1'b1;
                    end
                end
            end
            sacc_pkg::SACC_ABORT_WAIT: begin
                // [RQ14] Two bit periods before acquisition
                // Starts written here are dropped; software must retry
                if (!active) begin
                    state_next = sacc_pkg::SACC_IDLE;
                end else if (tick_if.tick) begin
                    period_next = period_reg + 4'h1;
                    if (period_reg + 4'h1 == `SACC_ABORT_PERIODS) begin
                        state_next = sacc_pkg::SACC_IDLE;
                    end
                end
            end
            default: state_next = sacc_pkg::SACC_IDLE;
        endcase
        // [RQ6] Software clear; a same-cycle set wins, so a
        // completion landing on the clear write is never lost
        if (done_flag_clear_in && !done_event) begin
            flag_next = 1'b0;
        end
    end

    // ---------------------------------------------
    // Comparator synchroniser
    // ---------------------------------------------
    // Comparator is asynchronous; only the second flop is read
    always_comb begin
        cmp_sync_next = {cmp_sync_reg[0], comparator_in};
    end

    // Synchroniser registers
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmp_sync_reg <= 2'h0;
        end else begin
            cmp_sync_reg <= cmp_sync_next;
        end
    end

    // ---------------------------------------------
    // Sequencer registers
    // ---------------------------------------------
    // [RQ15] Synchronous reset to idle and disabled values
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= sacc_pkg::SACC_IDLE;
            period_reg <= 4'h0;
            sar_reg <= 10'h000;
            result_reg <= `SACC_RESULT_RST;
            flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            period_reg <= period_next;
            sar_reg <= sar_next;
            result_reg <= result_next;
            flag_reg <= flag_next;
        end
    end

    // ---------------------------------------------
    // Outputs
    // ---------------------------------------------
    // [RQ2] Selected channel to the multiplexer
    assign mux_channel_out = input_channel_select_in;
    // [RQ19] Hold capacitor open during conversion
    assign hold_disconnect_out = state_reg == sacc_pkg::SACC_CONVERT;
    // Acquiring whenever enabled, idle and awake
    // The abort wait ends in idle, so acquisition restarts itself
    assign acquire_out = active && state_reg == sacc_pkg::SACC_IDLE;
    // Trial code: resolved bits plus the bit under test
    // Sample period and the final edge show only settled bits
    assign dac_code_out = (period_reg == 4'h0 || period_reg > 4'hA) ?
        sar_reg : (sar_reg | bit_mask(period_reg));
    // [RQ12] Start bit reads zero once done or aborted
    assign start_done_out = state_reg == sacc_pkg::SACC_CONVERT;
    // Flag straight from its register
    assign conversion_done_flag_out = flag_reg;
    // [RQ7] Interrupt request
    assign conversion_irq_out = flag_reg && conversion_irq_enable_in;
    // [RQ8] Right-justified, upper six bits zero
    assign result_high_byte_out = {6'h00, result_reg[9:8]};
    assign result_low_byte_out = result_reg[7:0];
endmodule : sacc_control

// file: tb/sacc_analog_model.sv
// Analog side model: comparator of a held level against the trial code
module sacc_analog_model (
    // Trial code and held level
    input wire logic [9:0] dac_code_in,
    input wire logic [9:0] level_in,
    // Comparator result
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // High keeps the trial bit; an ideal, noiseless comparator
    assign comparator_out = (dac_code_in <= level_in);
endmodule : sacc_analog_model

// file: tb/sacc_properties.sv
// Concurrent checks on the conversion control ports
module sacc_properties (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Software control bits
    input wire logic converter_enable_in,
    input wire logic sleep_in,
    input wire logic start_set_in,
    input wire logic start_clear_in,
    input wire logic done_flag_clear_in,
    input wire logic conversion_irq_enable_in,
    input wire logic [4:0] input_channel_select_in,
    // Design outputs
    input wire logic acquire_out,
    input wire logic start_done_out,
    input wire logic hold_disconnect_out,
    input wire logic conversion_done_flag_out,
    input wire logic conversion_irq_out,
    input wire logic [4:0] mux_channel_out,
    input wire logic [7:0] result_high_byte_out,
    input wire logic [7:0] result_low_byte_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_irq_from_flag: assert property (
        conversion_irq_out ==
        (conversion_done_flag_out && conversion_irq_enable_in))
        else $error("irq not flag and enable");
    a_high_bits_zero: assert property (
        result_high_byte_out[7:2] == 6'h00)
        else $error("upper result bits set");
    a_mux_follows: assert property (
        mux_channel_out == input_channel_select_in)
        else $error("mux channel wrong");
    a_start_taken: assert property (
        start_set_in && acquire_out |=> start_done_out)
        else $error("start not taken");
    a_disabled_idle: assert property (
        !converter_enable_in [*2] |-> !start_done_out)
        else $error("converting while disabled");
    a_sleep_idle: assert property (
        sleep_in [*2] |-> !start_done_out)
        else $error("converting in sleep");
    a_flag_sticky: assert property (
        conversion_done_flag_out && !done_flag_clear_in |=>
        conversion_done_flag_out)
        else $error("flag lost");
    a_flag_on_done: assert property (
        $rose(conversion_done_flag_out) |-> $fell(start_done_out))
        else $error("flag without completion");
    a_result_moves: assert property (
        $changed({result_high_byte_out, result_low_byte_out}) &&
        $past(rst_n_in) |-> $fell(start_done_out) &&
        conversion_done_flag_out)
        else $error("result changed outside completion");
    a_hold_in_conv: assert property (
        hold_disconnect_out == start_done_out)
        else $error("hold switch wrong");
    a_reset_ends: assert property (
        @(posedge clk_in) disable iff (1'b0)
        !rst_n_in |=> !start_done_out && !conversion_done_flag_out)
        else $error("reset left state");
    a_abort_stops: assert property (
        start_clear_in && start_done_out |=> !start_done_out)
        else $error("abort not taken");
    a_done_sets_flag: assert property (
        (start_done_out && !start_clear_in && converter_enable_in &&
        !sleep_in) ##1 !start_done_out |-> conversion_done_flag_out)
        else $error("completion without flag");
    cover property ($fell(start_done_out) && conversion_done_flag_out);
    cover property (start_set_in && acquire_out);
    cover property (conversion_irq_out);
    cover property (start_clear_in && start_done_out);
endmodule : sacc_properties
bind sacc_control sacc_properties i_sacc_properties (.*);

// file: tb/sar_adc_conversion_control_bench.sv
// Self-checking bench of the conversion control block
module sar_adc_conversion_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED %0t mismatch", $time); end end
    logic clk_in = 0, rst_n_in = 0, converter_enable_in = 0, sleep_in = 0;
    logic start_set_in = 0, start_clear_in = 0, done_flag_clear_in = 0;
    logic conversion_irq_enable_in = 0, rc_clock_in = 0, comparator_in;
    logic [4:0] input_channel_select_in = 0, mux_channel_out;
    logic [2:0] conv_clock_select_in = 3'h1;
    logic hold_disconnect_out, acquire_out, start_done_out;
    logic conversion_done_flag_out, conversion_irq_out;
    logic [9:0] dac_code_out, vin = 0, exp_res = 0;
    logic [7:0] result_high_byte_out, result_low_byte_out;
    logic [2:0] codes [8] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7, 3'h0, 3'h4};
    int failures = 0, num_checks = 0, cyc = 0;
    sacc_control i_sacc_control (.*);
    sacc_analog_model i_sacc_analog_model (.dac_code_in(dac_code_out),
        .level_in(vin), .comparator_out(comparator_in));
    // Clocks; RC source unrelated in phase to the system clock
    always #50 clk_in = ~clk_in;
    always #370 rc_clock_in = ~rc_clock_in;
    // Hang guard, well above the longest expected run
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 60000) begin
            failures++;
            print_verdict();
        end
    end
    // Bit period in system clocks, zero for the RC source
    function automatic int div(input logic [2:0] cs);
        case (cs)
            3'h1: return 8;
            3'h5: return 16;
            3'h2: return 32;
            3'h6: return 64;
            default: return 0;
        endcase
    endfunction : div
    // One-cycle software write: 0 start, 1 abort, 2 flag clear
    task automatic go(input int k);
        @(negedge clk_in);
        start_set_in = (k == 0);
        start_clear_in = (k == 1);
        done_flag_clear_in = (k == 2);
        @(negedge clk_in);
        {start_set_in, start_clear_in, done_flag_clear_in} = 3'h0;
    endtask : go
    // Ten RC periods in system clocks, from the RC half period above
    localparam int RC_CLKS = 74;
    // Full or aborted conversion on a random channel and level
    task automatic conv(input logic [2:0] cs, input logic ab);
        int n;
        int d;
        d = div(cs);
        n = 0;
        conv_clock_select_in = cs;
        conversion_irq_enable_in = 1'($urandom);
        input_channel_select_in = 5'($urandom);
        vin = 10'($urandom);
        go(2);
        `CHK(conversion_done_flag_out, 1'b0)
        repeat (4) @(negedge clk_in);
        `CHK(mux_channel_out, input_channel_select_in)
        go(0);
        `CHK(start_done_out, 1'b1)
        `CHK(hold_disconnect_out, 1'b1)
        if (ab) begin
            repeat (20) @(negedge clk_in);
            go(1);
            while (acquire_out !== 1'b1 && n < 1000) begin
                @(negedge clk_in);
                n++;
            end
            `CHK(n, 2 * d)
            `CHK(conversion_done_flag_out, 1'b0)
        end else begin
            // Poll the start bit until it reads zero
            while (start_done_out === 1'b1 && n < 1000) begin
                @(negedge clk_in);
                n++;
            end
            if (d > 0) `CHK(n, 11 * d)
            else `CHK(n >= RC_CLKS && n <= RC_CLKS + 10, 1'b1)
            exp_res = vin;
            `CHK(conversion_done_flag_out, 1'b1)
            `CHK(conversion_irq_out, conversion_irq_enable_in)
            `CHK(hold_disconnect_out, 1'b0)
            repeat (3) @(negedge clk_in);
            `CHK(conversion_done_flag_out, 1'b1)
        end
        `CHK(result_low_byte_out, exp_res[7:0])
        `CHK(result_high_byte_out, {6'h00, exp_res[9:8]})
    endtask : conv
    task print_verdict;
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    initial begin
        void'($urandom(39));
        repeat (6) @(negedge clk_in);
        rst_n_in = 1;
        // Start while disabled is ignored
        go(0);
        `CHK(start_done_out, 1'b0)
        // Enable in its own write, then start later
        converter_enable_in = 1;
        sleep_in = 1;
        go(0);
        `CHK(start_done_out, 1'b0)
        sleep_in = 0;
        // Ideal model, no bit time limit; clock is not 8 MHz
        for (int i = 0; i < 8; i++) conv(codes[i], 1'b0);
        for (int i = 0; i < 6; i++) conv(codes[$urandom % 4], 1'b0);
        conv(3'h1, 1'b1);
        conv(3'h5, 1'b1);
        // Reset in mid-conversion
        go(0);
        repeat (20) @(negedge clk_in);
        rst_n_in = 0;
        converter_enable_in = 0;
        @(negedge clk_in);
        rst_n_in = 1;
        `CHK(start_done_out, 1'b0)
        `CHK({result_high_byte_out, result_low_byte_out}, 16'h0000)
        exp_res = 0;
        converter_enable_in = 1;
        conv(3'h2, 1'b0);
        // Clear write on the completion edge with the flag set: set wins
        conv_clock_select_in = 3'h1;
        go(0);
        repeat (11 * div(3'h1) - 2) @(negedge clk_in);
        go(2);
        `CHK(conversion_done_flag_out, 1'b1)
        print_verdict();
    end
endmodule : sar_adc_conversion_control_bench
